/* core/tec_top.sv */
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "tec_defines.svh"
module tec_top #(
    parameter int CNT_W = 16
) (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       event_input_in,
    output logic      [7:0] rdata_out,
    output logic            irq_out,
    output logic            wake_out
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    localparam logic [CNT_W-1:0] ALL_ONES = {CNT_W{1'b1}};
    localparam bit               WIDE     = (CNT_W == 16);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   preload_q;
    logic               edge_sel_q;
    logic               count_enable_q;
    tec_pkg::tec_mode_e mode_q;
    tec_pkg::tec_pw_e   pw_q;
    logic               flag_q;
    logic               ien_q;
    logic               blk_q;
    logic [1:0]         div_q;

    logic [15:0]        cnt16;
    logic [7:0]         wbuf;
    logic [7:0]         rbuf;
    logic               pin_lvl;
    logic               pin_rise;
    logic               pin_fall;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic wr_ctrl;
    logic wr_irqc;
    logic wr_low;
    logic wr_load;
    logic rd_cnt;
    logic rd_high;
    logic [CNT_W-1:0] load_val;

    assign wr_ctrl = wr_in && hit(addr_in, `TEC_OFF_CTRL);
    assign wr_irqc = wr_in && hit(addr_in, `TEC_OFF_IRQC);
    assign wr_low  = wr_in && hit(addr_in, `TEC_OFF_LOW);
    assign rd_high = rd_in && hit(addr_in, `TEC_OFF_HIGH);
    assign wr_load = WIDE ? (wr_in && hit(addr_in, `TEC_OFF_HIGH)) : wr_low;
    assign rd_cnt  = WIDE ? rd_high : (rd_in && hit(addr_in, `TEC_OFF_LOW));
    assign cnt16   = 16'(cnt_q);
    assign load_val = WIDE ? CNT_W'({wdata_in, wbuf}) : CNT_W'(wdata_in);

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    tec_edge_sync u_sync (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .pin_in    (event_input_in),
        .level_out (pin_lvl),
        .rise_out  (pin_rise),
        .fall_out  (pin_fall)
    );

    tec_byte_pair u_bytes (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .wr_low_in  (wr_low && WIDE),
        .rd_high_in (rd_high && WIDE),
        .wdata_in   (wdata_in),
        .cnt_low_in (cnt16[7:0]),
        .wbuf_out   (wbuf),
        .rbuf_out   (rbuf)
    );

    // ----------------------------------------
    // Instruction clock enable
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_q <= 2'h0;
        end else if (div_q == `TEC_INSTR_DIV) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    logic instr_tick;
    assign instr_tick = (div_q == `TEC_INSTR_DIV);

    // ----------------------------------------
    // Count source selection
    // ----------------------------------------
    logic act_edge;
    logic pw_start;
    logic pw_end;
    logic tick;
    logic ovf;

    assign act_edge = edge_sel_q ? pin_fall : pin_rise;
    assign pw_start = edge_sel_q ? pin_rise : pin_fall;
    assign pw_end   = edge_sel_q ? pin_fall : pin_rise;

    always_comb begin
        tick = 1'b0;
        case (mode_q)
            tec_pkg::TEC_MODE_EVENT: tick = act_edge;
            tec_pkg::TEC_MODE_TIMER: tick = instr_tick;
            tec_pkg::TEC_MODE_PULSE: tick = instr_tick && (pw_q == tec_pkg::TEC_PW_MEAS);
            default:                 tick = 1'b0;
        endcase
        tick = tick && count_enable_q && !rd_cnt && !blk_q;
    end

    // Overflow at all ones, then reload preload
    assign ovf = tick && (cnt_q == ALL_ONES);

    // ----------------------------------------
    // Read block
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= rd_cnt;
        end
    end

    // ----------------------------------------
    // Counter and preload
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            preload_q <= '0;
        end else if (wr_load) begin
            preload_q <= load_val;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else if (wr_load && !count_enable_q) begin
            cnt_q <= load_val;
        end else if (ovf) begin
            cnt_q <= preload_q;
        end else if (tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic pw_done_now;
    assign pw_done_now = (pw_q == tec_pkg::TEC_PW_MEAS) && count_enable_q && pw_end;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            edge_sel_q <= `TEC_EDGE_RST;
            mode_q     <= tec_pkg::TEC_MODE_UNUSED;
        end else if (wr_ctrl) begin
            edge_sel_q <= wdata_in[`TEC_CTRL_EDGE];
            mode_q     <= tec_pkg::tec_mode_e'(wdata_in[`TEC_CTRL_MHI:`TEC_CTRL_MLO]);
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            count_enable_q <= 1'b0;
        // Only writes clear in other modes
        end else if (wr_ctrl) begin
            count_enable_q <= wdata_in[`TEC_CTRL_EN];
        end else if (pw_done_now && mode_q == tec_pkg::TEC_MODE_PULSE) begin
            count_enable_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pulse width sequencer
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pw_q <= tec_pkg::TEC_PW_IDLE;
        end else begin
            case (pw_q)
                tec_pkg::TEC_PW_IDLE: begin
                    if (count_enable_q && mode_q == tec_pkg::TEC_MODE_PULSE && pw_start) begin
                        pw_q <= tec_pkg::TEC_PW_MEAS;
                    end
                end
                tec_pkg::TEC_PW_MEAS: begin
                    if (!count_enable_q || mode_q != tec_pkg::TEC_MODE_PULSE) begin
                        pw_q <= tec_pkg::TEC_PW_IDLE;
                    end else if (pw_end) begin
                        pw_q <= tec_pkg::TEC_PW_DONE;
                    end
                end
                tec_pkg::TEC_PW_DONE: begin
                    if (count_enable_q) begin
                        pw_q <= tec_pkg::TEC_PW_IDLE;
                    end
                end
                default: pw_q <= tec_pkg::TEC_PW_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Interrupt control bits
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_q <= 1'b0;
        // Overflow sets flag, wins over clear
        end else if (ovf) begin
            flag_q <= 1'b1;
        end else if (wr_irqc) begin
            flag_q <= wdata_in[`TEC_FLAG_BIT];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ien_q <= 1'b0;
        end else if (wr_irqc) begin
            ien_q <= wdata_in[`TEC_IEN_BIT];
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out  <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_out  <= (flag_q || ovf) && ien_q;
            wake_out <= ovf;
        end
    end

    logic [7:0] ctrl_rd;
    logic [7:0] irqc_rd;

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`TEC_CTRL_EDGE]              = edge_sel_q;
        ctrl_rd[`TEC_CTRL_EN]                = count_enable_q;
        ctrl_rd[`TEC_CTRL_MHI:`TEC_CTRL_MLO] = mode_q;
        irqc_rd = 8'h00;
        irqc_rd[`TEC_FLAG_BIT] = flag_q;
        irqc_rd[`TEC_IEN_BIT]  = ien_q;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (!rd_in) begin
            rdata_out <= 8'h00;
        end else if (hit(addr_in, `TEC_OFF_CTRL)) begin
            rdata_out <= ctrl_rd;
        end else if (hit(addr_in, `TEC_OFF_IRQC)) begin
            rdata_out <= irqc_rd;
        end else if (WIDE && hit(addr_in, `TEC_OFF_HIGH)) begin
            rdata_out <= cnt16[15:8];
        end else if (hit(addr_in, `TEC_OFF_LOW)) begin
            rdata_out <= WIDE ? rbuf : cnt16[7:0];
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_pw_start;
        pw_q == tec_pkg::TEC_PW_IDLE && count_enable_q && !wr_ctrl
            && mode_q == tec_pkg::TEC_MODE_PULSE && pw_start;
    endsequence

    sequence s_pw_end;
        pw_q == tec_pkg::TEC_PW_MEAS && count_enable_q && !wr_ctrl
            && mode_q == tec_pkg::TEC_MODE_PULSE && pw_end;
    endsequence

    property p_ovf_reload;
        @(posedge mclk_in) disable iff (rst_in)
        (ovf && !wr_load) |=> (cnt_q == $past(preload_q));
    endproperty
    a_ovf_reload: assert property (p_ovf_reload) else $error("no reload on overflow");

    property p_ovf_flag;
        @(posedge mclk_in) disable iff (rst_in)
        ovf |=> (flag_q && wake_out) ##1 (!wake_out || $past(ovf));
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("flag or wake missing");

    property p_ctrl_zero;
        @(posedge mclk_in) disable iff (rst_in)
        (rd_in && hit(addr_in, `TEC_OFF_CTRL)) |=> (rdata_out[2:0] == 3'h0 && !rdata_out[5]);
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused control bits set");

    property p_stopped_hold;
        @(posedge mclk_in) disable iff (rst_in)
        (!count_enable_q && !wr_load) |=> $stable(cnt_q);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold) else $error("counter moved while off");

    property p_no_self_clear;
        @(posedge mclk_in) disable iff (rst_in)
        (count_enable_q && !wr_ctrl && mode_q != tec_pkg::TEC_MODE_PULSE) |=> count_enable_q;
    endproperty
    a_no_self_clear: assert property (p_no_self_clear) else $error("enable self cleared");

    property p_pw_cycle;
        @(posedge mclk_in) disable iff (rst_in)
        s_pw_end |=> (!count_enable_q && pw_q == tec_pkg::TEC_PW_DONE);
    endproperty
    a_pw_cycle: assert property (p_pw_cycle) else $error("measurement did not end");

    property p_pw_begin;
        @(posedge mclk_in) disable iff (rst_in)
        s_pw_start |=> pw_q == tec_pkg::TEC_PW_MEAS;
    endproperty
    a_pw_begin: assert property (p_pw_begin) else $error("measurement did not start");

    property p_pw_hold;
        @(posedge mclk_in) disable iff (rst_in)
        (pw_q == tec_pkg::TEC_PW_DONE && mode_q == tec_pkg::TEC_MODE_PULSE
            && !wr_ctrl && !wr_load) |=> $stable(cnt_q);
    endproperty
    a_pw_hold: assert property (p_pw_hold) else $error("result not held");

    property p_read_block;
        @(posedge mclk_in) disable iff (rst_in)
        rd_cnt |=> $stable(cnt_q);
    endproperty
    a_read_block: assert property (p_read_block) else $error("count during read");

    property p_direct_load;
        @(posedge mclk_in) disable iff (rst_in)
        (wr_load && !count_enable_q) |=> (cnt_q == preload_q);
    endproperty
    a_direct_load: assert property (p_direct_load) else $error("stopped load failed");

    property p_irq_masked;
        @(posedge mclk_in) disable iff (rst_in)
        (!ien_q && !wr_irqc) |=> !irq_out;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");

    property p_low_buffered;
        @(posedge mclk_in) disable iff (rst_in)
        (wr_low && WIDE) |=> $stable(preload_q);
    endproperty
    a_low_buffered: assert property (p_low_buffered) else $error("low write hit preload");

endmodule : tec_top

/* core/tec_defines.svh */
// What this block does
// - Count up from present value to all ones
// - Overflow reloads preload and sets request flag
// - Control bits 0-2 and 5 read zero
// - Edge select: 0 rising, 1 falling
// - Count enable bit: 0 stop, 1 run
// - Mode bits: 01 event, 10 timer, 11 pulse
// - Pulse mode measures once, then clears enable
// - Result held until software re-enables
// - Pulse measurement starts on edges, not levels
// - Overflow in pulse mode reloads and flags too
// - Event and timer modes never self-clear enable
// - Overflow wakes the halted processor
// - Interrupt enable zero suppresses interrupt service
// - Disabled: preload write also loads counter
// - Enabled: preload write touches preload only
// - Counter read blocks the count clock briefly
// - Event mode uses pin, timer uses instruction clock
// - Pulse mode counts instruction clock while level persists
// - Low write buffered; high write loads sixteen bits
// - High read latches low byte for later read
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TEC_OFF_IRQC   8'h0b
`define TEC_OFF_HIGH   8'h0c
`define TEC_OFF_LOW    8'h0d
`define TEC_OFF_CTRL   8'h0e

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define TEC_CTRL_EDGE  3
`define TEC_CTRL_EN    4
`define TEC_CTRL_MLO   6
`define TEC_CTRL_MHI   7
`define TEC_EDGE_RST   1'b1
`define TEC_FLAG_BIT   5
`define TEC_IEN_BIT    2

// ----------------------------------------
// Timing
// ----------------------------------------
`define TEC_INSTR_DIV  2'h3

`endif

/* core/tec_pkg.sv */
package tec_pkg;

    typedef enum logic [1:0] {
        TEC_MODE_UNUSED = 2'h0,
        TEC_MODE_EVENT  = 2'h1,
        TEC_MODE_TIMER  = 2'h2,
        TEC_MODE_PULSE  = 2'h3
    } tec_mode_e;

    typedef enum logic [2:0] {
        TEC_PW_IDLE = 3'h1,
        TEC_PW_MEAS = 3'h2,
        TEC_PW_DONE = 3'h4
    } tec_pw_e;

endpackage : tec_pkg

/* core/tec_edge_sync.sv */
`timescale 1ns/10ps
module tec_edge_sync (
    input  wire logic mclk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;
    assign fall_out  = ~sync_q & prev_q;
endmodule : tec_edge_sync

/* core/tec_byte_pair.sv */
`timescale 1ns/10ps
module tec_byte_pair (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       wr_low_in,
    input  wire logic       rd_high_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [7:0] cnt_low_in,
    output logic      [7:0] wbuf_out,
    output logic      [7:0] rbuf_out
);
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wbuf_out <= 8'h00;
        end else if (wr_low_in) begin
            wbuf_out <= wdata_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rbuf_out <= 8'h00;
        end else if (rd_high_in) begin
            rbuf_out <= cnt_low_in;
        end
    end
endmodule : tec_byte_pair

/* dv/tec_pin_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// External event pin source
// ----------------------------------------
module tec_pin_model (
    input  wire logic mclk_in,
    output logic      pin_out
);
    initial pin_out = 1'b0;

    // Level changes land just after a clock edge
    task automatic drive(input logic lvl, input int hold);
        @(posedge mclk_in);
        pin_out <= lvl;
        repeat (hold) @(posedge mclk_in);
    endtask : drive

    task automatic pulse(input int width, input int gap);
        drive(1'b1, width);
        drive(1'b0, gap);
    endtask : pulse
endmodule : tec_pin_model

/* dv/tec_top_tb.sv */
`timescale 1ns/10ps
module tec_top_tb;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  wdata_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    wire logic   event_input_in;
    logic [7:0]  rdata_out;
    logic        irq_out;
    logic        wake_out;
    int          miscompares = 0;
    int          tests_run = 0;
    int          wakes = 0;
    logic [15:0] v;
    logic [15:0] keep;

    always #50 mclk_in = ~mclk_in;

    tec_top #(.CNT_W(16)) dut (
        .mclk_in        (mclk_in),
        .rst_in         (rst_in),
        .addr_in        (addr_in),
        .wdata_in       (wdata_in),
        .wr_in          (wr_in),
        .rd_in          (rd_in),
        .event_input_in (event_input_in),
        .rdata_out      (rdata_out),
        .irq_out        (irq_out),
        .wake_out       (wake_out)
    );

    tec_pin_model pin (
        .mclk_in (mclk_in),
        .pin_out (event_input_in)
    );

    always @(posedge mclk_in) begin
        if (wake_out === 1'b1) begin
            wakes++;
        end
    end

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] in_rng(input logic [15:0] x, input int lo, input int hi);
        return {15'h0000, (x >= lo) && (x <= hi)};
    endfunction : in_rng

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask : rd_chk

    // High byte first so the low byte comes from the same instant
    task automatic rd16(output logic [15:0] x);
        rd_reg(8'h0c, x[15:8]);
        rd_reg(8'h0d, x[7:0]);
    endtask : rd16

    task automatic wr16(input logic [15:0] x);
        wr_reg(8'h0d, x[7:0]);
        wr_reg(8'h0c, x[15:8]);
    endtask : wr16

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #5_000_000;
        miscompares++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd_chk(8'h0e, 8'h08);
        rd_chk(8'h0b, 8'h00);
        rd_chk(8'h20, 8'h00);
        wr_reg(8'h0e, 8'h27);
        rd_chk(8'h0e, 8'h00);
        wr_reg(8'h0e, 8'h48);
        rd_chk(8'h0e, 8'h48);
        wr16(16'h1234);
        rd16(v);
        check(v, 16'h1234);
        wr_reg(8'h0d, 8'h55);
        rd16(v);
        check(v, 16'h1234);
        // Event counting on rising, then falling edges
        wr16(16'h0000);
        wr_reg(8'h0e, 8'h50);
        repeat (3) pin.pulse(4, 4);
        repeat (6) @(posedge mclk_in);
        rd16(v);
        check(v, 16'h0003);
        wr_reg(8'h0e, 8'h58);
        pin.drive(1'b1, 8);
        rd16(v);
        check(v, 16'h0003);
        pin.drive(1'b0, 8);
        rd16(v);
        check(v, 16'h0004);
        // Overflow reloads, flags, wakes
        wr_reg(8'h0e, 8'h48);
        wr16(16'hfffe);
        wr_reg(8'h0b, 8'h04);
        wr_reg(8'h0e, 8'h58);
        repeat (2) pin.pulse(4, 4);
        repeat (6) @(posedge mclk_in);
        check({15'h0000, irq_out}, 16'h0001);
        check(wakes[15:0], 16'h0001);
        rd_chk(8'h0b, 8'h24);
        rd_chk(8'h0e, 8'h58);
        rd16(v);
        check(v, 16'hfffe);
        wr16(16'h1000);
        rd16(v);
        check(v, 16'hfffe);
        repeat (2) pin.pulse(4, 4);
        repeat (6) @(posedge mclk_in);
        rd16(v);
        check(v, 16'h1000);
        wr_reg(8'h0b, 8'h20);
        @(posedge mclk_in);
        #1 check({15'h0000, irq_out}, 16'h0000);
        wr_reg(8'h0b, 8'h00);
        rd_chk(8'h0b, 8'h00);
        // Timer mode on the instruction clock
        wr_reg(8'h0e, 8'h00);
        wr16(16'h0000);
        wr_reg(8'h0e, 8'h90);
        repeat (40) @(posedge mclk_in);
        rd16(v);
        check(in_rng(v, 9, 11), 16'h0001);
        wr_reg(8'h0e, 8'h80);
        rd16(keep);
        repeat (20) @(posedge mclk_in);
        rd16(v);
        check(v, keep);
        // Pulse width measurement with an overflow inside
        pin.drive(1'b1, 4);
        wr16(16'hfff0);
        wr_reg(8'h0e, 8'hd8);
        repeat (20) @(posedge mclk_in);
        rd16(v);
        check(v, 16'hfff0);
        pin.drive(1'b0, 8);
        rd16(v);
        check(v, 16'hfff0);
        pin.pulse(80, 10);
        rd_chk(8'h0e, 8'hc8);
        rd16(keep);
        check(in_rng(keep, 16'hfff3, 16'hfff5), 16'h0001);
        rd_chk(8'h0b, 8'h20);
        pin.pulse(40, 10);
        rd16(v);
        check(v, keep);
        // Rearm by setting the enable again
        wr16(16'h0000);
        wr_reg(8'h0e, 8'hd8);
        pin.pulse(40, 10);
        rd_chk(8'h0e, 8'hc8);
        rd16(v);
        check(in_rng(v, 10, 11), 16'h0001);
        report_and_stop();
    end
endmodule : tec_top_tb
